// >>> include/slupa_regs.svh
// Register offsets, field positions, reset values and counts of the user port allocator.
// Assumes inclusion by bare name from design files under core/.
`ifndef SLUPA_REGS_SVH
`define SLUPA_REGS_SVH

`define SLUPA_ADDR_W 8
`define SLUPA_OFS_CTRL 8'h00
`define SLUPA_OFS_STATUS 8'h04
`define SLUPA_OFS_VCOUNT 8'h08

`define SLUPA_CTRL_NFC_EN 0
`define SLUPA_CTRL_RESET 32'h0000_0001

`define SLUPA_STAT_LANE_UP 0
`define SLUPA_STAT_CHAN_UP 1
`define SLUPA_STAT_XOFF 2
`define SLUPA_STAT_FIFO_FULL 3
`define SLUPA_STAT_FIFO_EMPTY 4

`define SLUPA_VERIFY_NEEDED 3'h4
`define SLUPA_FIFO_DEPTH 32
`define SLUPA_DATA_W 64
`define SLUPA_KEEP_W 8

`endif

// >>> include/slupa_pkg.sv
// Types shared by the user port allocator, its link partner model and its bench.
// Assumes slupa_regs.svh is on the include path.
`include "slupa_regs.svh"

package slupa_pkg;

    typedef struct packed {
        logic [`SLUPA_DATA_W-1:0] data;
        logic [`SLUPA_KEEP_W-1:0] keep;
        logic last;
    } slupa_beat_t;

    typedef enum logic [1:0] {
        INIT_RESET = 2'b00,
        INIT_LANE = 2'b01,
        INIT_VERIFY = 2'b10,
        INIT_UP = 2'b11
    } slupa_init_t;

endpackage : slupa_pkg

// >>> core/slupa_fifo.sv
// Flip-flop FIFO with valid and ready on both sides and a synchronous clear.
// Assumes one clock and a reset already synchronised by the parent.
`timescale 1ns/1ps

module slupa_fifo #(
    parameter int WIDTH = 73,
    parameter int DEPTH = 32
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic clr_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wptr_q;
    logic [AW:0] rptr_q;
    logic full;
    logic empty;
    logic push;
    logic pop;

    // The extra pointer bit tells full from empty when the indices meet.
    assign full = (wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]);
    assign empty = (wptr_q == rptr_q);
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign push = in_valid_i && !full;
    assign pop = out_ready_i && !empty;
    assign out_data_o = mem_q[rptr_q[AW-1:0]];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wptr_q[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wptr_q <= '0;
        end else if (clr_i) begin
            wptr_q <= '0;
        end else if (push) begin
            wptr_q <= wptr_q + 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rptr_q <= '0;
        end else if (clr_i) begin
            rptr_q <= '0;
        end else if (pop) begin
            rptr_q <= rptr_q + 1'b1;
        end
    end

endmodule : slupa_fifo

// >>> core/slupa_top.sv
// User port allocator of a lane-based serial link: transmit channel sharing,
// link initialisation gating and receive qualification.
// Assumes lane-side strobes run on core_clk_i; the three status pins are asynchronous.
`timescale 1ns/1ps
`include "slupa_regs.svh"

// Operation
// [RULE1] Flow-control request forces transmit ready low.
// [RULE2] Flow-control request inputs are active high.
// [RULE3] User control block valid forces ready low.
// [RULE4] Flow-off stops normal data until flow-on.
// [RULE5] User holds word until transmit ready high.
// [RULE6] User marks valid bytes on last beat.
// [RULE7] Receive outputs meaningful only while valid high.
// [RULE8] Unlocked clock or reset blocks initialisation.
// [RULE9] Power-down keeps lane and channel down.
// [RULE10] Channel up after lane up, four verifications.
// [RULE11] User waits for channel up before data.
module slupa_top (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [`SLUPA_ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire logic pll_not_locked_i,
    input wire logic power_down_i,
    input wire logic block_sync_i,
    input wire logic nfc_tx_valid_i,
    input wire logic ufc_tx_req_i,
    input wire logic user_k_tx_valid_i,
    input wire logic rx_xoff_i,
    input wire logic rx_xon_i,
    input wire logic rx_verify_i,
    input wire logic s_tx_tvalid_i,
    input wire slupa_pkg::slupa_beat_t s_tx_beat_i,
    output logic s_tx_tready_o,
    output logic link_tx_valid_o,
    output slupa_pkg::slupa_beat_t link_tx_beat_o,
    input wire logic link_tx_ready_i,
    input wire logic link_rx_valid_i,
    input wire slupa_pkg::slupa_beat_t link_rx_beat_i,
    output logic m_rx_tvalid_o,
    output slupa_pkg::slupa_beat_t m_rx_beat_o,
    output logic lane_up_o,
    output logic channel_up_o
);
    logic [1:0] rst_sync_q;
    logic rst_q;
    logic [2:0] pin_raw;
    logic [2:0] pin_s1_q;
    logic [2:0] pin_s2_q;
    logic [2:0] pin_s3_q;
    logic [2:0] pin_q;
    logic unlocked;
    logic pwr_down;
    logic blk_sync;
    logic hold;
    slupa_pkg::slupa_init_t state_q;
    slupa_pkg::slupa_init_t state_d;
    logic [2:0] vcount_q;
    logic nfc_en_q;
    logic xoff_q;
    logic flow_req;
    logic tx_pause;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_push;
    logic fifo_pop_ok;
    slupa_pkg::slupa_beat_t fifo_out;
    logic [31:0] rdata_q;

    // Reset is asserted at once and released through two flip-flops.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_q = rst_sync_q[1];

    // A pin level counts only once the second and third stages agree, so a
    // metastable first stage can never reach the decision logic.
    // The lock and power-down stages reset to their link-holding level, so the
    // link stays held until those pins have really been sampled.
    assign pin_raw = {block_sync_i, power_down_i, pll_not_locked_i};
    for (genvar g = 0; g < 3; g++) begin : g_pin
        always_ff @(posedge core_clk_i or negedge rst_q) begin
            if (!rst_q) begin
                pin_s1_q[g] <= (g != 2);
                pin_s2_q[g] <= (g != 2);
                pin_s3_q[g] <= (g != 2);
                pin_q[g] <= (g != 2);
            end else begin
                pin_s1_q[g] <= pin_raw[g];
                pin_s2_q[g] <= pin_s1_q[g];
                pin_s3_q[g] <= pin_s2_q[g];
                if (pin_s2_q[g] == pin_s3_q[g]) begin
                    pin_q[g] <= pin_s3_q[g];
                end
            end
        end
    end
    assign unlocked = pin_q[0];
    assign pwr_down = pin_q[1];
    assign blk_sync = pin_q[2];
    assign hold = unlocked || pwr_down; // RULE8 RULE9

    // Initialisation sequence.
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            slupa_pkg::INIT_RESET: begin
                state_d = slupa_pkg::INIT_LANE;
            end
            slupa_pkg::INIT_LANE: begin
                if (blk_sync) begin
                    state_d = slupa_pkg::INIT_VERIFY;
                end
            end
            slupa_pkg::INIT_VERIFY: begin
                if (!blk_sync) begin
                    state_d = slupa_pkg::INIT_LANE;
                end else if (rx_verify_i && vcount_q == `SLUPA_VERIFY_NEEDED - 3'h1) begin
                    state_d = slupa_pkg::INIT_UP; // RULE10
                end
            end
            slupa_pkg::INIT_UP: begin
                if (!blk_sync) begin
                    state_d = slupa_pkg::INIT_LANE;
                end
            end
        endcase
        if (hold) begin
            state_d = slupa_pkg::INIT_RESET; // RULE8 RULE9
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_q) begin
        if (!rst_q) begin
            state_q <= slupa_pkg::INIT_RESET; // RULE8
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_q) begin
        if (!rst_q) begin
            vcount_q <= 3'h0;
        end else if (state_d != slupa_pkg::INIT_VERIFY) begin
            vcount_q <= (state_d == slupa_pkg::INIT_UP) ? `SLUPA_VERIFY_NEEDED : 3'h0;
        end else if (rx_verify_i) begin
            vcount_q <= vcount_q + 3'h1; // RULE10
        end
    end

    assign lane_up_o = (state_q == slupa_pkg::INIT_VERIFY) || (state_q == slupa_pkg::INIT_UP);
    assign channel_up_o = (state_q == slupa_pkg::INIT_UP); // RULE10

    // Flow-off state; an xoff in the same cycle as an xon wins.
    always_ff @(posedge core_clk_i or negedge rst_q) begin
        if (!rst_q) begin
            xoff_q <= 1'b0;
        end else if (!channel_up_o || !nfc_en_q) begin
            xoff_q <= 1'b0;
        end else if (rx_xoff_i) begin
            xoff_q <= 1'b1; // RULE4
        end else if (rx_xon_i) begin
            xoff_q <= 1'b0; // RULE4
        end
    end

    // Any high request level claims the channel for flow control or a control block.
    assign flow_req = nfc_tx_valid_i || ufc_tx_req_i || user_k_tx_valid_i; // RULE1 RULE2 RULE3
    assign tx_pause = nfc_en_q && xoff_q; // RULE4
    assign s_tx_tready_o = fifo_in_ready && channel_up_o && !flow_req; // RULE1 RULE3 RULE11
    assign fifo_push = s_tx_tvalid_i && s_tx_tready_o; // RULE5
    assign fifo_pop_ok = channel_up_o && !tx_pause; // RULE4
    assign link_tx_valid_o = fifo_out_valid && fifo_pop_ok;
    assign link_tx_beat_o = fifo_out;

    // The buffer is flushed when the channel drops, so stale frames never
    // leak into the next session.
    slupa_fifo #(
        .WIDTH($bits(slupa_pkg::slupa_beat_t)),
        .DEPTH(`SLUPA_FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_i(core_clk_i),
        .rst_n_i(rst_q),
        .clr_i(!channel_up_o),
        .in_valid_i(fifo_push),
        .in_ready_o(fifo_in_ready),
        .in_data_i(s_tx_beat_i),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(link_tx_ready_i && fifo_pop_ok),
        .out_data_o(fifo_out)
    );

    // Receive beats are passed on only while the channel is up.
    always_ff @(posedge core_clk_i or negedge rst_q) begin
        if (!rst_q) begin
            m_rx_tvalid_o <= 1'b0;
        end else begin
            m_rx_tvalid_o <= link_rx_valid_i && channel_up_o; // RULE7
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_q) begin
        if (!rst_q) begin
            m_rx_beat_o <= '0;
        end else if (link_rx_valid_i) begin
            m_rx_beat_o <= link_rx_beat_i; // RULE7
        end
    end

    // Register port.
    always_ff @(posedge core_clk_i or negedge rst_q) begin
        if (!rst_q) begin
            // Only the enable bit of the control reset word is kept.
            nfc_en_q <= 1'(`SLUPA_CTRL_RESET >> `SLUPA_CTRL_NFC_EN);
        end else if (reg_wr_i && reg_addr_i == `SLUPA_OFS_CTRL) begin
            nfc_en_q <= reg_wdata_i[`SLUPA_CTRL_NFC_EN];
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_q) begin
        if (!rst_q) begin
            rdata_q <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            rdata_q <= 32'h0000_0000;
            unique case (reg_addr_i)
                `SLUPA_OFS_CTRL: begin
                    rdata_q[`SLUPA_CTRL_NFC_EN] <= nfc_en_q;
                end
                `SLUPA_OFS_STATUS: begin
                    rdata_q[`SLUPA_STAT_LANE_UP] <= lane_up_o;
                    rdata_q[`SLUPA_STAT_CHAN_UP] <= channel_up_o;
                    rdata_q[`SLUPA_STAT_XOFF] <= xoff_q;
                    rdata_q[`SLUPA_STAT_FIFO_FULL] <= !fifo_in_ready;
                    rdata_q[`SLUPA_STAT_FIFO_EMPTY] <= !fifo_out_valid;
                end
                `SLUPA_OFS_VCOUNT: begin
                    rdata_q[2:0] <= vcount_q;
                end
                default: begin
                    rdata_q <= 32'h0000_0000;
                end
            endcase
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end
    assign reg_rdata_o = rdata_q;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_q);

    // Checks stay quiet while the internal reset is low, because the pin
    // stages have not settled yet and the state machine is forced idle.
    a_nfc_blocks_ready: assert property (nfc_tx_valid_i |-> !s_tx_tready_o) // RULE1
        else $error("transmit ready high during native flow request");
    a_ufc_blocks_ready: assert property (ufc_tx_req_i |-> !s_tx_tready_o) // RULE2
        else $error("transmit ready high during user flow request");
    a_req_active_high: assert property ( // RULE2
        (channel_up_o && fifo_in_ready && !nfc_tx_valid_i && !ufc_tx_req_i
            && !user_k_tx_valid_i) |-> s_tx_tready_o)
        else $error("transmit ready low with no request pending");
    a_userk_blocks_ready: assert property (user_k_tx_valid_i |-> !s_tx_tready_o) // RULE3
        else $error("transmit ready high during control block");
    // A flow-on in the first cycle of the pause may release data one cycle later.
    a_xoff_stops_tx: assert property ( // RULE4
        ($past(rx_xoff_i) && $past(channel_up_o) && $past(nfc_en_q) && channel_up_o
            && nfc_en_q) |-> !link_tx_valid_o
            ##1 (!link_tx_valid_o || $past(rx_xon_i) || !nfc_en_q))
        else $error("normal data sent after flow-off");
    a_rx_valid_gate: assert property ( // RULE7
        m_rx_tvalid_o |-> ($past(link_rx_valid_i) && $past(channel_up_o)))
        else $error("receive valid without channel and link beat");
    a_rx_beat_taken: assert property ( // RULE7
        (link_rx_valid_i && channel_up_o) |=> (m_rx_tvalid_o
            && m_rx_beat_o == $past(link_rx_beat_i)))
        else $error("receive beat not passed on");
    a_hold_blocks_tx: assert property ( // RULE9
        (unlocked || pwr_down) |=> (!s_tx_tready_o && !link_tx_valid_o))
        else $error("transmit path open while link held");
    a_unlock_holds: assert property (unlocked |=> !lane_up_o && !channel_up_o) // RULE8
        else $error("lane up while clock unlocked");
    a_pwrdn_holds: assert property (pwr_down |=> (!lane_up_o && !channel_up_o) [*1]) // RULE9
        else $error("link up during power down");
    a_chan_after_four: assert property ( // RULE10
        $rose(channel_up_o) |-> ($past(lane_up_o) && $past(vcount_q) == 3'h3
            && $past(rx_verify_i)))
        else $error("channel up without four verifications");

    c_channel_up: cover property ($rose(channel_up_o));
    c_tx_beat: cover property (link_tx_valid_o && link_tx_ready_i && link_tx_beat_o.last);
    c_fifo_full: cover property (channel_up_o && !fifo_in_ready);
    c_xoff_xon: cover property (xoff_q ##[1:50] !xoff_q);
    c_rx_last: cover property (m_rx_tvalid_o && m_rx_beat_o.last);

endmodule : slupa_top

// >>> tb/slupa_link_model.sv
// Model of the remote link partner: lane sync, verification, flow messages and traffic.
// Assumes the allocator's clock and tasks called from the bench after a rising edge.
`timescale 1ns/1ps

module slupa_link_model (
    input wire logic clk_i,
    input wire logic sync_en_i,
    input wire logic stall_i,
    input wire logic link_tx_valid_i,
    input wire slupa_pkg::slupa_beat_t link_tx_beat_i,
    output logic link_tx_ready_o,
    output logic block_sync_o,
    output logic rx_verify_o,
    output logic rx_xoff_o,
    output logic rx_xon_o,
    output logic link_rx_valid_o,
    output slupa_pkg::slupa_beat_t link_rx_beat_o
);
    slupa_pkg::slupa_beat_t got_q[$];

    assign block_sync_o = sync_en_i;
    assign link_tx_ready_o = !stall_i;

    initial begin
        rx_verify_o = 1'b0;
        rx_xoff_o = 1'b0;
        rx_xon_o = 1'b0;
        link_rx_valid_o = 1'b0;
        link_rx_beat_o = '0;
    end

    always @(posedge clk_i) begin
        if (link_tx_valid_i && link_tx_ready_o) begin
            got_q.push_back(link_tx_beat_i);
        end
    end

    // Kind 0 is a verification sequence, 1 a flow-off and 2 a flow-on message.
    task automatic pulse(input int kind);
        @(posedge clk_i);
        rx_verify_o <= (kind == 0);
        rx_xoff_o <= (kind == 1);
        rx_xon_o <= (kind == 2);
        @(posedge clk_i);
        rx_verify_o <= 1'b0;
        rx_xoff_o <= 1'b0;
        rx_xon_o <= 1'b0;
    endtask : pulse

    // The data lines carry the inverse afterwards, so stale data never looks valid.
    task automatic send_rx(input slupa_pkg::slupa_beat_t bt);
        @(posedge clk_i);
        link_rx_valid_o <= 1'b1;
        link_rx_beat_o <= bt;
        @(posedge clk_i);
        link_rx_valid_o <= 1'b0;
        link_rx_beat_o <= ~bt;
    endtask : send_rx
endmodule : slupa_link_model

// >>> tb/tb_slupa_top.sv
// Self-checking bench of the user port allocator.
// Assumes the link partner model and a 10 MHz clock.
`timescale 1ns/1ps
`include "slupa_regs.svh"

module tb_slupa_top;
    logic clk, rst_n, wr, rd, pll, pd, nfc, ufc, uk, tvalid, tready, ltv, lready;
    logic lrv, mrv, lane, chan, bsync, ver, xoff, xon, stall, sync_en;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, rv;
    slupa_pkg::slupa_beat_t tbeat, ltb, lrb, mrb;
    int errors, total_checks, n, k;

    slupa_top dut_u (.core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .pll_not_locked_i(pll), .power_down_i(pd), .block_sync_i(bsync),
        .nfc_tx_valid_i(nfc), .ufc_tx_req_i(ufc), .user_k_tx_valid_i(uk),
        .rx_xoff_i(xoff), .rx_xon_i(xon), .rx_verify_i(ver), .s_tx_tvalid_i(tvalid),
        .s_tx_beat_i(tbeat), .s_tx_tready_o(tready), .link_tx_valid_o(ltv),
        .link_tx_beat_o(ltb), .link_tx_ready_i(lready), .link_rx_valid_i(lrv),
        .link_rx_beat_i(lrb), .m_rx_tvalid_o(mrv), .m_rx_beat_o(mrb),
        .lane_up_o(lane), .channel_up_o(chan));

    slupa_link_model model_u (.clk_i(clk), .sync_en_i(sync_en), .stall_i(stall),
        .link_tx_valid_i(ltv), .link_tx_beat_i(ltb), .link_tx_ready_o(lready),
        .block_sync_o(bsync), .rx_verify_o(ver), .rx_xoff_o(xoff), .rx_xon_o(xon),
        .link_rx_valid_o(lrv), .link_rx_beat_o(lrb));

    task automatic chk(input string what, input logic [72:0] exp, input logic [72:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : reg_read

    task automatic wait_up(input bit ch);
        n = 0;
        while ((ch ? chan : lane) !== 1'b1 && n < 60) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(ch ? "channel up" : "lane up", 1'b1, ch ? chan : lane);
    endtask : wait_up

    // Leaves the beat offered; the caller lowers valid when the burst is over.
    task automatic send_beat(input slupa_pkg::slupa_beat_t bt);
        tvalid <= 1'b1;
        tbeat <= bt;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (tready !== 1'b1 && n < 50);
        chk("tx accept", 1'b1, tready);
        @(posedge clk);
    endtask : send_beat

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        #(5000 * 100);
        errors++;
        give_verdict();
    end

    initial begin
        rst_n = 1'b0;
        pll = 1'b1;
        {wr, rd, pd, nfc, ufc, uk, tvalid, stall, sync_en} = '0;
        {addr, wdata, tbeat} = '0;
        repeat (6) @(posedge clk);
        #1;
        chk("lane in reset", 1'b0, lane);
        rst_n <= 1'b1;
        sync_en <= 1'b1;
        repeat (12) @(posedge clk);
        #1;
        chk("lane while unlocked", 1'b0, lane);
        pll <= 1'b0;
        pd <= 1'b1;
        repeat (12) @(posedge clk);
        #1;
        chk("lane in power down", 1'b0, lane);
        chk("channel in power down", 1'b0, chan);
        pd <= 1'b0;
        wait_up(0);
        reg_read(`SLUPA_OFS_CTRL, rv);
        chk("ctrl reset", `SLUPA_CTRL_RESET, rv);
        reg_read(8'h0C, rv);
        chk("unmapped read", 32'h0000_0000, rv);
        reg_write(`SLUPA_OFS_STATUS, 32'hFFFF_FFFF);
        reg_read(`SLUPA_OFS_STATUS, rv);
        chk("status lane only", 32'h0000_0011, rv);
        repeat (3) model_u.pulse(0);
        repeat (4) @(posedge clk);
        #1;
        chk("channel after three", 1'b0, chan);
        model_u.pulse(0);
        wait_up(1);
        reg_read(`SLUPA_OFS_VCOUNT, rv);
        chk("verify count", 32'h0000_0004, rv);
        for (int i = 0; i < 3; i++) begin
            {nfc, ufc, uk} <= 3'b100 >> i;
            @(posedge clk);
            #1;
            chk("tready claimed", 1'b0, tready);
            {nfc, ufc, uk} <= 3'b000;
            @(posedge clk);
            #1;
            chk("tready free", 1'b1, tready);
        end
        model_u.pulse(1);
        send_beat('{64'h0123_4567_89AB_CDEF, 8'h0F, 1'b1});
        tvalid <= 1'b0;
        repeat (5) begin
            @(negedge clk);
            chk("link valid in flow off", 1'b0, ltv);
        end
        reg_read(`SLUPA_OFS_STATUS, rv);
        chk("status flow off", 32'h0000_0007, rv);
        model_u.pulse(2);
        for (int i = 0; i < 20 && model_u.got_q.size() == 0; i++) @(posedge clk);
        chk("beat after flow on", {64'h0123_4567_89AB_CDEF, 8'h0F, 1'b1},
            model_u.got_q[0]);
        stall <= 1'b1;
        k = 0;
        for (int i = 0; i < 40; i++) begin
            tvalid <= 1'b1;
            tbeat <= '{64'(i), 8'hFF, 1'b0};
            @(negedge clk);
            if (tready !== 1'b1) break;
            @(posedge clk);
            k++;
        end
        tvalid <= 1'b0;
        chk("fill count", `SLUPA_FIFO_DEPTH, k);
        reg_read(`SLUPA_OFS_STATUS, rv);
        chk("status full", 32'h0000_000B, rv);
        stall <= 1'b0;
        for (int i = 0; i < 80 && model_u.got_q.size() < 33; i++) @(posedge clk);
        for (int i = 0; i < 32; i++) chk("drain order", {64'(i), 8'hFF, 1'b0}, model_u.got_q[i+1]);
        reg_read(`SLUPA_OFS_STATUS, rv);
        chk("status empty", 32'h0000_0013, rv);
        reg_write(`SLUPA_OFS_CTRL, 32'h0000_0000);
        model_u.pulse(1);
        reg_read(`SLUPA_OFS_STATUS, rv);
        chk("status nfc off", 32'h0000_0013, rv);
        reg_read(`SLUPA_OFS_CTRL, rv);
        chk("ctrl nfc off", 32'h0000_0000, rv);
        model_u.send_rx('{64'hFEED_0000_BEEF_1111, 8'h3F, 1'b1});
        #1;
        chk("rx valid", 1'b1, mrv);
        chk("rx beat", {64'hFEED_0000_BEEF_1111, 8'h3F, 1'b1}, mrb);
        @(posedge clk);
        #1;
        chk("rx valid drop", 1'b0, mrv);
        give_verdict();
    end
endmodule : tb_slupa_top
